// >>> design/sdi_map.vh
`ifndef SDI_MAP_VH
`define SDI_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses on the register bus.
`define SDI_ADDR_W        16
`define SDI_OFS_PENDING   16'ha808
`define SDI_OFS_ENABLE    16'ha848
`define SDI_OFS_TRIGMODE  16'ha854
`define SDI_OFS_FUNC      16'hc854
`define SDI_OFS_TXSTARTA  16'hc800
`define SDI_OFS_TXSTARTB  16'hc804
`define SDI_OFS_TXENDA    16'hc808
`define SDI_OFS_TXENDB    16'hc80c
`define SDI_OFS_TXCOUNT   16'hc810
`define SDI_OFS_RXSTARTA  16'hc814
`define SDI_OFS_RXSTARTB  16'hc818
`define SDI_OFS_RXENDA    16'hc81c
`define SDI_OFS_RXENDB    16'hc820
`define SDI_OFS_RXCOUNTA  16'hc824
`define SDI_OFS_RXCOUNTB  16'hc828
`define SDI_OFS_CTRL      16'hc830
`define SDI_OFS_DMASTAT   16'hc834

////////////////////////////////////////////////////////////////////////////////
// Pending and enable bit positions.
`define SDI_FLAG_W        15
`define SDI_FLAG_RESET    15'h0000
`define SDI_DONE_IDLE     4'hf
`define SDI_BIT_RXVAL     0
`define SDI_BIT_TXFREE    1
`define SDI_BIT_TXIDLE    2
`define SDI_BIT_RXOVF     3
`define SDI_BIT_TXUND     4
`define SDI_BIT_I2C_LO    5
`define SDI_I2C_W         4
`define SDI_BIT_RXULDA    9
`define SDI_BIT_RXULDB    10
`define SDI_BIT_TXULDA    11
`define SDI_BIT_TXULDB    12
`define SDI_BIT_FRMERR    13
`define SDI_BIT_PARERR    14

////////////////////////////////////////////////////////////////////////////////
// Trigger mode, function select and channel control fields.
`define SDI_TRIG_W        3
`define SDI_TRIG_RESET    3'h0
`define SDI_FUNC_W        2
`define SDI_FUNC_OFF      2'h0
`define SDI_FUNC_UART     2'h1
`define SDI_FUNC_SPI      2'h2
`define SDI_FUNC_I2C      2'h3
`define SDI_CTL_RXLOAD_LO 0
`define SDI_CTL_TXLOAD_LO 2
`define SDI_CTL_RXRST     4
`define SDI_CTL_TXRST     5

`endif

// >>> design/sdi_event_detect.v
`timescale 1ns/1ps

module sdi_event_detect #(
  parameter         W    = 1,
  // Resting level of each source, so that leaving reset is never taken as an edge.
  parameter [W-1:0] IDLE = {W{1'b0}}
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rstn,
  // Status levels and per-bit mode, 1 selects level
  input  wire [W-1:0] level,
  input  wire [W-1:0] levelMode,
  // One event per rising edge, or every cycle while high
  output wire [W-1:0] evt
);

  reg [W-1:0] prevLevel;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prevLevel <= IDLE;
    end else begin
      prevLevel <= level;
    end
  end

  assign evt = (levelMode & level) | (~levelMode & level & ~prevLevel);

endmodule // sdi_event_detect

// >>> design/sdi_dma_channel.v
`timescale 1ns/1ps

module sdi_dma_channel #(
  parameter AW    = 16,
  parameter IS_RX = 0
) (
  // Clock and reset
  input  wire                  sys_clk,
  input  wire                  rstn,
  // Software control
  input  wire                  chanReset,
  input  wire [1:0]            loadReq,
  input  wire [1:0]            wrStart,
  input  wire [1:0]            wrEnd,
  input  wire [1:0]            wrCount,
  input  wire [AW-1:0]         wrData,
  // Serial FIFO side
  input  wire                  fifoReady,
  input  wire [7:0]            fifoRdata,
  output reg                   fifoStrobe,
  output reg  [7:0]            dataOut,
  // Memory side
  output reg                   memReq,
  output reg  [AW-1:0]         memAddr,
  input  wire [7:0]            memRdata,
  input  wire                  memAck,
  // Readback
  output wire [2*AW-1:0]       bufStart,
  output wire [2*AW-1:0]       bufEnd,
  output wire [((IS_RX != 0) ? 2 : 1)*AW-1:0] countOut,
  output wire [1:0]            bufActive,
  output wire [1:0]            bufPending
);

  localparam NCNT = (IS_RX != 0) ? 2 : 1;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_MEM  = 2'h1;
  localparam [1:0] ST_GAP  = 2'h2;
  localparam [AW-1:0] ONE  = {{(AW-1){1'b0}}, 1'b1};

  reg  [1:0]    state;
  reg           actSel;
  reg           xferSel;
  reg  [1:0]    loaded;
  reg  [AW-1:0] startR [0:1];
  reg  [AW-1:0] endR   [0:1];
  reg  [AW-1:0] cntR   [0:NCNT-1];
  wire [AW-1:0] effCnt [0:1];
  wire [1:0]    unloadNow;
  integer       i;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gBuf
      localparam [0:0] IDX = g;
      wire [AW:0] reach;
      if (IS_RX != 0) begin : gRx
        assign effCnt[g] = cntR[g];
      end else begin : gTx
        // The shared count belongs to the active buffer; a pending one is at offset zero.
        assign effCnt[g] = (actSel == IDX) ? cntR[0] : {AW{1'b0}};
      end
      assign reach         = {1'b0, startR[g]} + {1'b0, effCnt[g]};
      assign unloadNow[g]  = loaded[g] && (reach > {1'b0, endR[g]});
      assign bufActive[g]  = loaded[g] && (actSel == IDX);
      assign bufPending[g] = loaded[g] && (actSel != IDX);
      assign bufStart[g*AW +: AW] = startR[g];
      assign bufEnd[g*AW +: AW]   = endR[g];
    end
    for (g = 0; g < NCNT; g = g + 1) begin : gCnt
      assign countOut[g*AW +: AW] = cntR[g];
    end
  endgenerate

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state      <= ST_IDLE;
      actSel     <= 1'b0;
      xferSel    <= 1'b0;
      loaded     <= 2'b00;
      memReq     <= 1'b0;
      memAddr    <= {AW{1'b0}};
      dataOut    <= 8'h00;
      fifoStrobe <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        startR[i] <= {AW{1'b0}};
        endR[i]   <= {AW{1'b0}};
      end
      for (i = 0; i < NCNT; i = i + 1) begin
        cntR[i] <= {AW{1'b0}};
      end
    end else begin
      fifoStrobe <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        if (wrStart[i]) begin
          startR[i] <= wrData;
        end
        if (wrEnd[i]) begin
          endR[i] <= wrData;
        end
      end
      if (chanReset) begin
        state  <= ST_IDLE;
        memReq <= 1'b0;
        loaded <= 2'b00;
        actSel <= 1'b0;
        for (i = 0; i < NCNT; i = i + 1) begin
          cntR[i] <= {AW{1'b0}};
        end
      end else begin
        case (state)
          ST_IDLE: begin
            if (bufActive[actSel] && !unloadNow[actSel] && fifoReady) begin
              xferSel <= actSel;
              memAddr <= startR[actSel] + effCnt[actSel];
              memReq  <= 1'b1;
              state   <= ST_MEM;
              if (IS_RX != 0) begin
                fifoStrobe <= 1'b1;
                dataOut    <= fifoRdata;
              end
            end
          end
          ST_MEM: begin
            if (memAck) begin
              memReq <= 1'b0;
              state  <= ST_GAP;
              cntR[(IS_RX != 0) ? xferSel : 1'b0] <=
                cntR[(IS_RX != 0) ? xferSel : 1'b0] + ONE;
              if (IS_RX == 0) begin
                fifoStrobe <= 1'b1;
                dataOut    <= memRdata;
              end
            end
          end
          // The FIFO status needs a cycle to reflect the last strobe.
          ST_GAP:  state <= ST_IDLE;
          default: state <= ST_IDLE;
        endcase
        for (i = 0; i < 2; i = i + 1) begin
          if (unloadNow[i]) begin
            loaded[i] <= 1'b0;
          end
        end
        if ((!loaded[actSel] || unloadNow[actSel]) && loaded[~actSel] && !unloadNow[~actSel]) begin
          actSel <= ~actSel;
          if (IS_RX == 0) begin
            cntR[0] <= {AW{1'b0}};
          end
        end
        for (i = 0; i < 2; i = i + 1) begin
          if (loadReq[i] || ((IS_RX != 0) && wrCount[i] && !loaded[i])) begin
            loaded[i] <= 1'b1;
            if (!loaded[0] && !loaded[1]) begin
              actSel <= i[0];
            end
          end
          if (loadReq[i] && ((IS_RX != 0) || (!loaded[0] && !loaded[1]))) begin
            cntR[(IS_RX != 0) ? i : 0] <= {AW{1'b0}};
          end
          if ((IS_RX != 0) && wrCount[i]) begin
            cntR[(IS_RX != 0) ? i : 0] <= wrData;
          end
        end
      end
    end
  end

endmodule // sdi_dma_channel

// >>> design/sdi_serial_dma_irq.v
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sdi_map.vh"

module sdi_serial_dma_irq #(
  parameter AW = 16
) (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    rstn,
  // AHB-Lite slave
  input  wire                    hsel,
  input  wire [`SDI_ADDR_W-1:0]  haddr,
  input  wire [1:0]              htrans,
  input  wire                    hwrite,
  input  wire [2:0]              hsize,
  input  wire [31:0]             hwdata,
  input  wire                    hready,
  output reg                     hreadyout,
  output reg  [31:0]             hrdata,
  output reg                     hresp,
  // Serial controller status
  input  wire                    txIdleStatus,
  input  wire                    txSpaceStatus,
  input  wire                    rxValidStatus,
  input  wire                    rxFifoFull,
  input  wire                    rxCharArrive,
  input  wire                    rxCharParityErr,
  input  wire                    rxCharFrameErr,
  input  wire                    txUnderrun,
  input  wire [`SDI_I2C_W-1:0]   i2cEvents,
  // Transmit FIFO push port
  output wire                    txFifoPush,
  output wire [7:0]              txFifoData,
  // Receive FIFO pop port, data shown ahead of the pop
  input  wire [7:0]              rxFifoData,
  output wire                    rxFifoPop,
  // Transmit memory read port
  output wire                    txMemReq,
  output wire [AW-1:0]           txMemAddr,
  input  wire [7:0]              txMemRdata,
  input  wire                    txMemAck,
  // Receive memory write port
  output wire                    rxMemReq,
  output wire [AW-1:0]           rxMemAddr,
  output wire [7:0]              rxMemWdata,
  input  wire                    rxMemAck,
  // Controller function and interrupt
  output reg  [`SDI_FUNC_W-1:0]  functionSelect,
  output reg                     controllerIrqLine
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave state.

  reg                    dataPhase;
  reg                    dataWrite;
  reg [`SDI_ADDR_W-1:0]  dataAddr;
  reg [31:0]             readMux;
  wire                   addrTaken;
  wire                   wrEn;

  // Software registers.
  reg  [`SDI_FLAG_W-1:0] irqPending;
  reg  [`SDI_FLAG_W-1:0] irqEnableMask;
  reg  [`SDI_TRIG_W-1:0] irqTriggerMode;
  reg  [`SDI_FLAG_W-1:0] next_irqPending;
  reg  [`SDI_FLAG_W-1:0] eventSet;
  wire [`SDI_FLAG_W-1:0] pendingClear;

  // Channel wiring.
  wire                   wrCtl;
  wire [1:0]             txLoad;
  wire [1:0]             rxLoad;
  wire                   txReset;
  wire                   rxReset;
  wire [1:0]             txWrStart;
  wire [1:0]             txWrEnd;
  wire [1:0]             rxWrStart;
  wire [1:0]             rxWrEnd;
  wire [1:0]             rxWrCount;
  wire [2*AW-1:0]        txStart;
  wire [2*AW-1:0]        txEnd;
  wire [AW-1:0]          txCount;
  wire [2*AW-1:0]        rxStart;
  wire [2*AW-1:0]        rxEnd;
  wire [2*AW-1:0]        rxCount;
  wire [1:0]             txActive;
  wire [1:0]             txPending;
  wire [1:0]             rxActive;
  wire [1:0]             rxPending;
  wire [`SDI_TRIG_W-1:0] statusEvt;
  wire [3:0]             doneEvt;
  wire [31:0]            dmaStatus;

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave. Writes take no wait state; reads take one, so that a read
  // right behind a write sees the written value.

  assign addrTaken = hsel && htrans[1] && hready;
  assign wrEn      = dataPhase && dataWrite && hreadyout;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= {`SDI_ADDR_W{1'b0}};
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (addrTaken) begin
        dataPhase <= 1'b1;
        dataWrite <= hwrite;
        dataAddr  <= haddr;
        hreadyout <= hwrite;
      end else if (dataPhase && !dataWrite && !hreadyout) begin
        hrdata    <= readMux;
        hreadyout <= 1'b1;
      end else if (hreadyout) begin
        dataPhase <= 1'b0;
      end
    end
  end

  assign dmaStatus = {24'h000000, txPending, txActive, rxPending, rxActive};

  // Unmapped addresses read as zero.
  always @* begin
    readMux = 32'h00000000;
    case (dataAddr)
      `SDI_OFS_PENDING:  readMux = {{(32-`SDI_FLAG_W){1'b0}}, irqPending};
      `SDI_OFS_ENABLE:   readMux = {{(32-`SDI_FLAG_W){1'b0}}, irqEnableMask};
      `SDI_OFS_TRIGMODE: readMux = {{(32-`SDI_TRIG_W){1'b0}}, irqTriggerMode};
      `SDI_OFS_FUNC:     readMux = {{(32-`SDI_FUNC_W){1'b0}}, functionSelect};
      `SDI_OFS_TXSTARTA: readMux = {{(32-AW){1'b0}}, txStart[AW-1:0]};
      `SDI_OFS_TXSTARTB: readMux = {{(32-AW){1'b0}}, txStart[2*AW-1:AW]};
      `SDI_OFS_TXENDA:   readMux = {{(32-AW){1'b0}}, txEnd[AW-1:0]};
      `SDI_OFS_TXENDB:   readMux = {{(32-AW){1'b0}}, txEnd[2*AW-1:AW]};
      `SDI_OFS_TXCOUNT:  readMux = {{(32-AW){1'b0}}, txCount};
      `SDI_OFS_RXSTARTA: readMux = {{(32-AW){1'b0}}, rxStart[AW-1:0]};
      `SDI_OFS_RXSTARTB: readMux = {{(32-AW){1'b0}}, rxStart[2*AW-1:AW]};
      `SDI_OFS_RXENDA:   readMux = {{(32-AW){1'b0}}, rxEnd[AW-1:0]};
      `SDI_OFS_RXENDB:   readMux = {{(32-AW){1'b0}}, rxEnd[2*AW-1:AW]};
      `SDI_OFS_RXCOUNTA: readMux = {{(32-AW){1'b0}}, rxCount[AW-1:0]};
      `SDI_OFS_RXCOUNTB: readMux = {{(32-AW){1'b0}}, rxCount[2*AW-1:AW]};
      `SDI_OFS_DMASTAT:  readMux = dmaStatus;
      default:           readMux = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqEnableMask  <= `SDI_FLAG_RESET;
      irqTriggerMode <= `SDI_TRIG_RESET;
      functionSelect <= `SDI_FUNC_OFF;
    end else if (wrEn) begin
      if (dataAddr == `SDI_OFS_ENABLE) begin
        irqEnableMask <= hwdata[`SDI_FLAG_W-1:0];
      end
      if (dataAddr == `SDI_OFS_TRIGMODE) begin
        irqTriggerMode <= hwdata[`SDI_TRIG_W-1:0];
      end
      if (dataAddr == `SDI_OFS_FUNC) begin
        functionSelect <= hwdata[`SDI_FUNC_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel control decode. Load and reset bits act as write-one pulses.

  assign wrCtl   = wrEn && (dataAddr == `SDI_OFS_CTRL);
  assign txLoad  = wrCtl ? hwdata[`SDI_CTL_TXLOAD_LO +: 2] : 2'b00;
  assign rxLoad  = wrCtl ? hwdata[`SDI_CTL_RXLOAD_LO +: 2] : 2'b00;
  assign txReset = wrCtl && hwdata[`SDI_CTL_TXRST];
  assign rxReset = wrCtl && hwdata[`SDI_CTL_RXRST];

  assign txWrStart = {wrEn && (dataAddr == `SDI_OFS_TXSTARTB),
                      wrEn && (dataAddr == `SDI_OFS_TXSTARTA)};
  assign txWrEnd   = {wrEn && (dataAddr == `SDI_OFS_TXENDB),
                      wrEn && (dataAddr == `SDI_OFS_TXENDA)};
  assign rxWrStart = {wrEn && (dataAddr == `SDI_OFS_RXSTARTB),
                      wrEn && (dataAddr == `SDI_OFS_RXSTARTA)};
  assign rxWrEnd   = {wrEn && (dataAddr == `SDI_OFS_RXENDB),
                      wrEn && (dataAddr == `SDI_OFS_RXENDA)};
  assign rxWrCount = {wrEn && (dataAddr == `SDI_OFS_RXCOUNTB),
                      wrEn && (dataAddr == `SDI_OFS_RXCOUNTA)};

  //////////////////////////////////////////////////////////////////////////////
  // DMA channels.

  sdi_dma_channel #(
    .AW    (AW),
    .IS_RX (0)
  ) uTxChannel (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .chanReset  (txReset),
    .loadReq    (txLoad),
    .wrStart    (txWrStart),
    .wrEnd      (txWrEnd),
    .wrCount    (2'b00),
    .wrData     (hwdata[AW-1:0]),
    .fifoReady  (txSpaceStatus),
    .fifoRdata  (8'h00),
    .fifoStrobe (txFifoPush),
    .dataOut    (txFifoData),
    .memReq     (txMemReq),
    .memAddr    (txMemAddr),
    .memRdata   (txMemRdata),
    .memAck     (txMemAck),
    .bufStart   (txStart),
    .bufEnd     (txEnd),
    .countOut   (txCount),
    .bufActive  (txActive),
    .bufPending (txPending)
  );

  sdi_dma_channel #(
    .AW    (AW),
    .IS_RX (1)
  ) uRxChannel (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .chanReset  (rxReset),
    .loadReq    (rxLoad),
    .wrStart    (rxWrStart),
    .wrEnd      (rxWrEnd),
    .wrCount    (rxWrCount),
    .wrData     (hwdata[AW-1:0]),
    .fifoReady  (rxValidStatus),
    .fifoRdata  (rxFifoData),
    .fifoStrobe (rxFifoPop),
    .dataOut    (rxMemWdata),
    .memReq     (rxMemReq),
    .memAddr    (rxMemAddr),
    .memRdata   (8'h00),
    .memAck     (rxMemAck),
    .bufStart   (rxStart),
    .bufEnd     (rxEnd),
    .countOut   (rxCount),
    .bufActive  (rxActive),
    .bufPending (rxPending)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Event sources.

  sdi_event_detect #(
    .W (`SDI_TRIG_W)
  ) uStatusEvents (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .level     ({txIdleStatus, txSpaceStatus, rxValidStatus}),
    .levelMode (irqTriggerMode),
    .evt       (statusEvt)
  );

  // A falling active indication is a rising edge of its inverse.
  sdi_event_detect #(
    .W    (4),
    .IDLE (`SDI_DONE_IDLE)
  ) uDoneEvents (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .level     (~{txActive, rxActive}),
    .levelMode (4'h0),
    .evt       (doneEvt)
  );

  always @* begin
    eventSet                                   = `SDI_FLAG_RESET;
    eventSet[`SDI_BIT_RXVAL]                   = statusEvt[0];
    eventSet[`SDI_BIT_TXFREE]                  = statusEvt[1];
    eventSet[`SDI_BIT_TXIDLE]                  = statusEvt[2];
    eventSet[`SDI_BIT_RXOVF]                   = rxCharArrive && rxFifoFull;
    eventSet[`SDI_BIT_TXUND]                   = txUnderrun;
    eventSet[`SDI_BIT_I2C_LO +: `SDI_I2C_W]    = i2cEvents;
    eventSet[`SDI_BIT_RXULDA]                  = doneEvt[0];
    eventSet[`SDI_BIT_RXULDB]                  = doneEvt[1];
    eventSet[`SDI_BIT_TXULDA]                  = doneEvt[2];
    eventSet[`SDI_BIT_TXULDB]                  = doneEvt[3];
    // Character errors only exist in UART framing.
    eventSet[`SDI_BIT_FRMERR] = rxCharArrive && rxCharFrameErr &&
                                (functionSelect == `SDI_FUNC_UART);
    eventSet[`SDI_BIT_PARERR] = rxCharArrive && rxCharParityErr &&
                                (functionSelect == `SDI_FUNC_UART);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending flags and interrupt line. A new event beats a same-cycle clear.

  assign pendingClear = (wrEn && (dataAddr == `SDI_OFS_PENDING)) ?
                        hwdata[`SDI_FLAG_W-1:0] : `SDI_FLAG_RESET;

  always @* begin
    next_irqPending = (irqPending & ~pendingClear) | eventSet;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqPending        <= `SDI_FLAG_RESET;
      controllerIrqLine <= 1'b0;
    end else begin
      irqPending        <= next_irqPending;
      controllerIrqLine <= |(next_irqPending & irqEnableMask);
    end
  end

endmodule // sdi_serial_dma_irq

// >>> verification/sdi_mem_model.sv
`timescale 1ns/1ps

module sdi_mem_model #(parameter AW = 16) (
  // Clock, reset and answer speed
  input  wire          sys_clk,
  input  wire          rstn,
  input  wire          slow,
  // Transmit read port
  input  wire          txMemReq,
  input  wire [AW-1:0] txMemAddr,
  output wire [7:0]    txMemRdata,
  output reg           txMemAck,
  // Receive write port and its record
  input  wire          rxMemReq,
  input  wire [AW-1:0] rxMemAddr,
  input  wire [7:0]    rxMemWdata,
  output reg           rxMemAck,
  output reg  [AW-1:0] lastAddr,
  output reg  [7:0]    lastData
);
  reg  [1:0] waitCnt;
  wire [7:0] word = txMemAddr[7:0] ^ txMemAddr[AW-1:AW-8];
  // Outside an answer the bus shows the inverse, so stale data cannot pass.
  assign txMemRdata = txMemAck ? word : ~word;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {txMemAck, rxMemAck, waitCnt, lastAddr, lastData} <= 0;
    end else begin
      waitCnt  <= (txMemReq && !txMemAck) ? waitCnt + 2'h1 : 2'h0;
      txMemAck <= txMemReq && !txMemAck && (!slow || waitCnt == 2'h3);
      rxMemAck <= rxMemReq && !rxMemAck;
      if (rxMemReq && rxMemAck) begin
        lastAddr <= rxMemAddr;
        lastData <= rxMemWdata;
      end
    end
  end
endmodule // sdi_mem_model

// >>> verification/sdi_serial_dma_irq_asserts.sv
`timescale 1ns/1ps

module sdi_serial_dma_irq_asserts #(parameter AW = 16) (
  // Clock, reset and bus
  input wire          sys_clk,
  input wire          rstn,
  input wire          hsel,
  input wire [1:0]    htrans,
  input wire          hwrite,
  input wire          hready,
  input wire          hreadyout,
  input wire          hresp,
  // Channel ports
  input wire          txMemReq,
  input wire [AW-1:0] txMemAddr,
  input wire          txMemAck,
  input wire          txFifoPush,
  input wire          rxFifoPop,
  input wire          rxMemReq,
  input wire          rxMemAck
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence rdTaken; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence wrTaken; hsel && htrans[1] && hready && hwrite; endsequence
  sequence txDone; txMemReq && txMemAck; endsequence
  chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_read_wait: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  chk_write_nowait: assert property (wrTaken |=> hreadyout) else $error("write stalled");
  chk_req_hold: assert property (txMemReq && !txMemAck |=> txMemReq && $stable(txMemAddr))
    else $error("tx request dropped");
  chk_tx_push: assert property (txDone |=> txFifoPush && !txMemReq)
    else $error("no push after read");
  chk_push_gap: assert property (txFifoPush |=> !txFifoPush && !txMemReq)
    else $error("push not a pulse");
  chk_pop_write: assert property (rxFifoPop |=> rxMemReq && !rxFifoPop)
    else $error("pop without write");
  chk_rx_done: assert property (rxMemReq && rxMemAck |=> !rxMemReq ##1 !rxFifoPop)
    else $error("rx write not ended");
endmodule // sdi_serial_dma_irq_asserts

bind sdi_serial_dma_irq sdi_serial_dma_irq_asserts #(.AW(AW)) i_chk (
  .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .txMemReq(txMemReq),
  .txMemAddr(txMemAddr), .txMemAck(txMemAck), .txFifoPush(txFifoPush),
  .rxFifoPop(rxFifoPop), .rxMemReq(rxMemReq), .rxMemAck(rxMemAck));

// >>> verification/tb.sv
`timescale 1ns/1ps
`include "sdi_map.vh"

module tb;
  logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0, slow = 0;
  logic [1:0] htrans = 0;
  logic [15:0] haddr = 0, lastAddr, txMemAddr, rxMemAddr;
  logic [31:0] hwdata = 0, hrdata, d;
  logic [2:0] st = 0;
  logic [8:0] ev = 0;
  logic [7:0] txLog [0:7], txFifoData, rxMemWdata, txMemRdata, lastData;
  logic hready, hresp, txFifoPush, rxFifoPop, txMemReq, txMemAck, rxMemReq, rxMemAck, irq;
  logic [1:0] fsel;
  int err_count = 0, samples_checked = 0, nPush = 0;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (txFifoPush === 1'b1 && nPush < 8) begin
    txLog[nPush] <= txFifoData;
    nPush <= nPush + 1;
  end
  sdi_serial_dma_irq i_dut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .txIdleStatus(st[2]),
    .txSpaceStatus(st[1]), .rxValidStatus(st[0]), .rxFifoFull(ev[8]), .rxCharArrive(ev[7]),
    .rxCharParityErr(ev[6]), .rxCharFrameErr(ev[5]), .txUnderrun(ev[4]), .i2cEvents(ev[3:0]),
    .txFifoPush(txFifoPush), .txFifoData(txFifoData), .rxFifoData(st[0] ? 8'ha5 : 8'h5a),
    .rxFifoPop(rxFifoPop), .txMemReq(txMemReq), .txMemAddr(txMemAddr), .txMemRdata(txMemRdata),
    .txMemAck(txMemAck), .rxMemReq(rxMemReq), .rxMemAddr(rxMemAddr), .rxMemWdata(rxMemWdata),
    .rxMemAck(rxMemAck), .functionSelect(fsel), .controllerIrqLine(irq));
  sdi_mem_model i_mem (.sys_clk(sys_clk), .rstn(rstn), .slow(slow), .txMemReq(txMemReq),
    .txMemAddr(txMemAddr), .txMemRdata(txMemRdata), .txMemAck(txMemAck), .rxMemReq(rxMemReq),
    .rxMemAddr(rxMemAddr), .rxMemWdata(rxMemWdata), .rxMemAck(rxMemAck), .lastAddr(lastAddr),
    .lastData(lastData));
  task automatic tally_and_finish;
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reads right after an edge see the values from before it, as a slave would.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic until_rdy;
    int k;
    k = 0;
    do begin tick(1); k++; end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin err_count++; tally_and_finish; end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    until_rdy;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    until_rdy;
    d = hrdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v); bus(1, a, v); endtask
  task automatic rd(input logic [15:0] a); bus(0, a, 0); endtask
  task automatic waitbit(input int b);
    int k;
    for (k = 0; k < 60; k++) begin rd(`SDI_OFS_PENDING); if (d[b] === 1'b1) break; end
    `CHK("pend bit", 1'b1, d[b])
  endtask
  task automatic t_regs;
    rd(`SDI_OFS_PENDING); `CHK("pend rst", 32'h0, d)
    rd(16'h0100); `CHK("unmapped", 32'h0, d)
    for (int f = 0; f < 4; f++) begin
      wr(`SDI_OFS_FUNC, f);
      rd(`SDI_OFS_FUNC); `CHK("func", f[1:0], d[1:0])
      `CHK("func pin", f[1:0], fsel)
    end
  endtask
  task automatic t_events;
    wr(`SDI_OFS_ENABLE, 32'h7fff);
    for (int i = 0; i < 3; i++) begin
      st <= 3'h1 << i;
      tick(2);
      rd(`SDI_OFS_PENDING); `CHK("edge ev", 32'h1 << i, d)
      `CHK("irq", 1'b1, irq)
      wr(`SDI_OFS_PENDING, 32'h7fff);
      rd(`SDI_OFS_PENDING); `CHK("edge once", 32'h0, d)
      st <= 0;
      tick(1);
    end
    wr(`SDI_OFS_TRIGMODE, 32'h7);
    st <= 3'h7;
    wr(`SDI_OFS_PENDING, 32'h7fff);
    rd(`SDI_OFS_PENDING); `CHK("level ev", 32'h7, d)
    st <= 0;
    wr(`SDI_OFS_TRIGMODE, 32'h0);
    wr(`SDI_OFS_PENDING, 32'h7fff);
    wr(`SDI_OFS_FUNC, `SDI_FUNC_UART);
    ev <= 9'h1d5;
    tick(1);
    ev <= 9'h0aa;
    tick(1);
    ev <= 0;
    rd(`SDI_OFS_PENDING); `CHK("err ev", 32'h61f8, d)
    wr(`SDI_OFS_ENABLE, 32'h0);
    rd(`SDI_OFS_PENDING); `CHK("masked", 1'b0, irq)
    wr(`SDI_OFS_ENABLE, 32'h4000);
    wr(`SDI_OFS_PENDING, 32'h2000);
    rd(`SDI_OFS_PENDING); `CHK("kept", 1'b1, irq)
    wr(`SDI_OFS_PENDING, 32'h7fff);
    rd(`SDI_OFS_PENDING); `CHK("cleared", 1'b0, irq)
  endtask
  task automatic t_tx;
    slow <= 1;
    wr(`SDI_OFS_CTRL, 32'h30);
    wr(`SDI_OFS_TXSTARTA, 32'h100);
    wr(`SDI_OFS_TXENDA, 32'h101);
    wr(`SDI_OFS_TXSTARTB, 32'h210);
    wr(`SDI_OFS_TXENDB, 32'h210);
    wr(`SDI_OFS_CTRL, 32'h4);
    wr(`SDI_OFS_CTRL, 32'h8);
    rd(`SDI_OFS_DMASTAT); `CHK("tx states", 4'h9, d[7:4])
    st <= 3'h2;
    waitbit(12);
    st <= 0;
    `CHK("tx bytes", 32'h01000312, {txLog[0], txLog[1], 8'h03, txLog[2]})
    `CHK("tx done", 2'h3, d[12:11])
    rd(`SDI_OFS_TXCOUNT); `CHK("tx count", 32'h1, d)
  endtask
  task automatic t_rx;
    slow <= 0;
    wr(`SDI_OFS_RXSTARTA, 32'h300);
    wr(`SDI_OFS_RXENDA, 32'h300);
    wr(`SDI_OFS_CTRL, 32'h1);
    st <= 3'h1;
    waitbit(9);
    st <= 0;
    `CHK("rx write", 24'h300a5, {lastAddr, lastData})
    rd(`SDI_OFS_RXCOUNTA); `CHK("rx count", 32'h1, d)
    wr(`SDI_OFS_RXSTARTB, 32'h400);
    wr(`SDI_OFS_RXENDB, 32'h40f);
    wr(`SDI_OFS_RXCOUNTB, 32'h5);
    rd(`SDI_OFS_DMASTAT); `CHK("rx loaded", 1'b1, d[1] | d[3])
    wr(`SDI_OFS_RXENDB, 32'h404);
    waitbit(10);
    rd(`SDI_OFS_RXCOUNTB); `CHK("rx kept", 32'h5, d)
  endtask
  initial begin
    tick(4);
    rstn <= 1;
    tick(1);
    t_regs;
    t_events;
    t_tx;
    t_rx;
    tally_and_finish;
  end
endmodule // tb
